//--- pkg/peirq_pkg.sv
// constants, types and helpers for the pin edge and interval interrupt block
// assumes one 40 MHz clock, Avalon-MM register access, byte addressed words
// How it works
// [R1] bit pair per pin: 00 off, 01 falling only, 10 rising only
// [R2] both select bits set: request on every rising and falling edge
// [R3] rise and fall select registers, 8 bits, bit n controls pin n
// [R4] supply-enable bit 7 of clock gate register stops or feeds timer clock
// [R5] a request flag reads 1 while its request is pending, else 0
// [R6] pin one flag at low flags bit 3, timer flag high bit 2, write 0 clears
// [R7] mask 0 lets its request through to servicing, mask 1 blocks it
// [R8] pin one mask at low masks bit 3, timer mask at high masks bit 2
// [R9] control bit 15 runs the counter; 0 stops it and clears the count
// [R10] compare value bits 11..0, request every compare plus one count clocks
// [R11] source select bit 4: 0 subsystem clock, 1 low-speed oscillator clock
// [R12] pin synchronised before edge detection; flag holds until cleared or acked
package peirq_pkg;
	localparam logic [7:0] OFF_RISE = 8'h00;
	localparam logic [7:0] OFF_FALL = 8'h04;
	localparam logic [7:0] OFF_CLKGATE = 8'h08;
	localparam logic [7:0] OFF_SRCSEL = 8'h0C;
	localparam logic [7:0] OFF_FLAG_LO = 8'h10;
	localparam logic [7:0] OFF_MASK_LO = 8'h14;
	localparam logic [7:0] OFF_FLAG_HI = 8'h18;
	localparam logic [7:0] OFF_MASK_HI = 8'h1C;
	localparam logic [7:0] OFF_ITCTRL = 8'h20;
	localparam logic [7:0] OFF_FLAG_EXT = 8'h24;
	localparam logic [7:0] OFF_MASK_EXT = 8'h28;
	localparam int PIN_N = 8;
	localparam int PIN_LO_N = 6;
	localparam int PIN_LO_LSB = 2;
	localparam int TIMER_BIT = 2;
	localparam int SUPPLY_BIT = 7;
	localparam int SRCSEL_BIT = 4;
	localparam int RUN_BIT = 15;
	localparam int CMP_W = 12;
	localparam int IRQ_TIMER = 8;
	localparam int IRQ_N = 9;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [7:0] RST_MASK = 8'hFF;
	localparam logic RST_TMASK = 1'b1;
	localparam logic [CMP_W-1:0] RST_CMP = 12'hFFF;
	localparam logic [31:0] RD_ZERO = 32'h0000_0000;
	typedef enum logic [0:0] {
		PEIRQ_IDLE = 1'b0,
		PEIRQ_ANSWER = 1'b1
	} peirq_bus_state_t;
	typedef struct packed {
		logic run;
		logic [CMP_W-1:0] cmp;
	} peirq_timer_cfg_t;
	typedef struct packed {
		logic supplyEn;
		logic lowSel;
	} peirq_clk_cfg_t;
	function automatic logic edgeHit(input logic rise, input logic fall,
		input logic cur, input logic prev);
		edgeHit = (rise & cur & ~prev) | (fall & ~cur & prev);
	endfunction : edgeHit
	function automatic logic flagNext(input logic cur, input logic setEv,
		input logic clrEv);
		flagNext = setEv | (cur & ~clrEv);
	endfunction : flagNext
endpackage : peirq_pkg

//--- src/peirq_edge_detect.sv
// pin synchronisers and per-pin valid edge detection
// assumes pins are asynchronous to clock
`timescale 1ns/1ps
`default_nettype none
module peirq_edge_detect (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clkEn,
	input wire logic [peirq_pkg::PIN_N-1:0] pinIn,
	input wire logic [peirq_pkg::PIN_N-1:0] riseSel,
	input wire logic [peirq_pkg::PIN_N-1:0] fallSel,
	output logic [peirq_pkg::PIN_N-1:0] pinEdge
);
	logic [peirq_pkg::PIN_N-1:0] syncA_r;
	logic [peirq_pkg::PIN_N-1:0] syncB_r;
	logic [peirq_pkg::PIN_N-1:0] prev_r;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			syncA_r <= '0;
			syncB_r <= '0;
			prev_r <= '0;
		end else if (clkEn) begin
			syncA_r <= pinIn; // [R12]
			syncB_r <= syncA_r; // [R12]
			prev_r <= syncB_r;
		end
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pinEdge <= '0;
		end else if (clkEn) begin
			for (int i = 0; i < peirq_pkg::PIN_N; i++) begin
				pinEdge[i] <= peirq_pkg::edgeHit(riseSel[i], fallSel[i],
					syncB_r[i], prev_r[i]); // [R1] [R2] [R3]
			end
		end
	end
endmodule : peirq_edge_detect
`default_nettype wire

//--- src/peirq_interval_timer.sv
// 12-bit interval counter driven by a selected, gated count clock
// assumes count clocks are far slower than clock and asynchronous to it
`timescale 1ns/1ps
`default_nettype none
module peirq_interval_timer (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clkEn,
	input wire logic subClockIn,
	input wire logic lowOscClockIn,
	input wire peirq_pkg::peirq_clk_cfg_t clkCfg,
	input wire peirq_pkg::peirq_timer_cfg_t cfg,
	output logic intervalEvent,
	output logic [peirq_pkg::CMP_W-1:0] count
);
	logic [1:0] syncA_r;
	logic [1:0] syncB_r;
	logic [1:0] prev_r;
	logic [1:0] srcRise;
	logic countTick;
	// edge memory per source, so a source switch gives no false tick
	assign srcRise = syncB_r & ~prev_r;
	assign countTick = clkCfg.supplyEn & (clkCfg.lowSel ? srcRise[1] : srcRise[0]); // [R4] [R11]
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			syncA_r <= '0;
			syncB_r <= '0;
			prev_r <= '0;
		end else if (clkEn) begin
			syncA_r <= {lowOscClockIn, subClockIn};
			syncB_r <= syncA_r;
			prev_r <= syncB_r;
		end
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			count <= '0;
			intervalEvent <= 1'b0;
		end else if (clkEn) begin
			intervalEvent <= 1'b0;
			if (!cfg.run) begin
				count <= '0; // [R9]
			end else if (countTick) begin
				if (count == cfg.cmp) begin
					count <= '0; // [R10]
					intervalEvent <= 1'b1; // [R10]
				end else begin
					count <= count + 1'b1;
				end
			end
		end
	end
endmodule : peirq_interval_timer
`default_nettype wire

//--- src/peirq_top.sv
// register file, request flags and masks, Avalon-MM slave
// assumes an Avalon-MM master that holds each request until waitrequest is low
//
// Our own choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module peirq_top (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clkEn,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [peirq_pkg::PIN_N-1:0] pinIn,
	input wire logic subClockIn,
	input wire logic lowOscClockIn,
	input wire logic [peirq_pkg::IRQ_N-1:0] irqAck,
	output logic [peirq_pkg::IRQ_N-1:0] irqReq,
	output logic intervalTimerIrq,
	output logic [peirq_pkg::CMP_W-1:0] intervalCount
);
	peirq_pkg::peirq_bus_state_t busState_r;
	peirq_pkg::peirq_bus_state_t busState_nxt;
	logic [7:0] riseSel_r;
	logic [7:0] fallSel_r;
	logic [7:0] clkGate_r;
	logic [7:0] srcSel_r;
	logic [peirq_pkg::PIN_N-1:0] pinFlag_r;
	logic [peirq_pkg::PIN_N-1:0] pinMask_r;
	logic timerFlag_r;
	logic timerMask_r;
	logic itRun_r;
	logic [peirq_pkg::CMP_W-1:0] itCmp_r;
	logic [31:0] readMux;
	logic busReq;
	logic wrTake;
	logic [7:0] wordAddr;
	logic [peirq_pkg::PIN_N-1:0] pinEdge;
	logic intervalEvent;
	logic [peirq_pkg::PIN_N-1:0] pinSet;
	logic [peirq_pkg::PIN_N-1:0] pinClr;
	logic [peirq_pkg::PIN_N-1:0] pinMaskWr;
	logic [peirq_pkg::PIN_N-1:0] pinMaskVal;
	logic timerSet;
	logic timerClr;
	peirq_pkg::peirq_clk_cfg_t clkCfg;
	peirq_pkg::peirq_timer_cfg_t timerCfg;

	function automatic logic regHit(input logic [7:0] addr,
		input logic [7:0] off, input logic take, input logic lane);
		regHit = take & lane & (addr == off);
	endfunction : regHit

	// bus handshake
	assign busReq = avs_read | avs_write;
	assign wordAddr = {avs_address[7:2], 2'b00};
	assign wrTake = (busState_r == peirq_pkg::PEIRQ_ANSWER) & avs_write & clkEn;
	assign avs_waitrequest = busReq & (busState_r != peirq_pkg::PEIRQ_ANSWER);

	always_comb begin
		busState_nxt = busState_r;
		case (busState_r)
			peirq_pkg::PEIRQ_IDLE: begin
				if (busReq) begin
					busState_nxt = peirq_pkg::PEIRQ_ANSWER;
				end
			end
			peirq_pkg::PEIRQ_ANSWER: begin
				busState_nxt = peirq_pkg::PEIRQ_IDLE;
			end
			default: begin
				busState_nxt = peirq_pkg::PEIRQ_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			busState_r <= peirq_pkg::PEIRQ_IDLE;
		end else if (clkEn) begin
			busState_r <= busState_nxt;
		end
	end

	// read data sampled when the request is first seen
	always_comb begin
		readMux = peirq_pkg::RD_ZERO;
		case (wordAddr)
			peirq_pkg::OFF_RISE: begin
				readMux[7:0] = riseSel_r;
			end
			peirq_pkg::OFF_FALL: begin
				readMux[7:0] = fallSel_r;
			end
			peirq_pkg::OFF_CLKGATE: begin
				readMux[peirq_pkg::SUPPLY_BIT] = clkGate_r[peirq_pkg::SUPPLY_BIT];
			end
			peirq_pkg::OFF_SRCSEL: begin
				readMux[peirq_pkg::SRCSEL_BIT] = srcSel_r[peirq_pkg::SRCSEL_BIT];
			end
			peirq_pkg::OFF_FLAG_LO: begin
				readMux[peirq_pkg::PIN_LO_LSB +: peirq_pkg::PIN_LO_N] =
					pinFlag_r[peirq_pkg::PIN_LO_N-1:0]; // [R5] [R6]
			end
			peirq_pkg::OFF_MASK_LO: begin
				readMux[peirq_pkg::PIN_LO_LSB +: peirq_pkg::PIN_LO_N] =
					pinMask_r[peirq_pkg::PIN_LO_N-1:0]; // [R8]
			end
			peirq_pkg::OFF_FLAG_HI: begin
				readMux[peirq_pkg::TIMER_BIT] = timerFlag_r; // [R5] [R6]
			end
			peirq_pkg::OFF_MASK_HI: begin
				readMux[peirq_pkg::TIMER_BIT] = timerMask_r; // [R8]
			end
			peirq_pkg::OFF_ITCTRL: begin
				readMux[peirq_pkg::RUN_BIT] = itRun_r;
				readMux[peirq_pkg::CMP_W-1:0] = itCmp_r;
			end
			peirq_pkg::OFF_FLAG_EXT: begin
				readMux[peirq_pkg::PIN_N-peirq_pkg::PIN_LO_N-1:0] =
					pinFlag_r[peirq_pkg::PIN_N-1:peirq_pkg::PIN_LO_N];
			end
			peirq_pkg::OFF_MASK_EXT: begin
				readMux[peirq_pkg::PIN_N-peirq_pkg::PIN_LO_N-1:0] =
					pinMask_r[peirq_pkg::PIN_N-1:peirq_pkg::PIN_LO_N];
			end
			default: begin
				readMux = peirq_pkg::RD_ZERO;
			end
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			avs_readdata <= peirq_pkg::RD_ZERO;
		end else if (clkEn) begin
			if ((busState_r == peirq_pkg::PEIRQ_IDLE) && avs_read) begin
				avs_readdata <= readMux;
			end
		end
	end

	// edge select registers
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			riseSel_r <= peirq_pkg::RST_BYTE;
			fallSel_r <= peirq_pkg::RST_BYTE;
		end else begin
			if (regHit(wordAddr, peirq_pkg::OFF_RISE, wrTake, avs_byteenable[0])) begin
				riseSel_r <= avs_writedata[7:0]; // [R3]
			end
			if (regHit(wordAddr, peirq_pkg::OFF_FALL, wrTake, avs_byteenable[0])) begin
				fallSel_r <= avs_writedata[7:0]; // [R3]
			end
		end
	end

	// clock gate and count source select
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			clkGate_r <= peirq_pkg::RST_BYTE;
			srcSel_r <= peirq_pkg::RST_BYTE;
		end else begin
			if (regHit(wordAddr, peirq_pkg::OFF_CLKGATE, wrTake, avs_byteenable[0])) begin
				clkGate_r <= avs_writedata[7:0];
			end
			if (regHit(wordAddr, peirq_pkg::OFF_SRCSEL, wrTake, avs_byteenable[0])) begin
				srcSel_r <= avs_writedata[7:0];
			end
		end
	end

	assign clkCfg.supplyEn = clkGate_r[peirq_pkg::SUPPLY_BIT]; // [R4]
	assign clkCfg.lowSel = srcSel_r[peirq_pkg::SRCSEL_BIT]; // [R11]

	// interval timer control
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			itRun_r <= 1'b0;
			itCmp_r <= peirq_pkg::RST_CMP;
		end else begin
			if (regHit(wordAddr, peirq_pkg::OFF_ITCTRL, wrTake, avs_byteenable[0])) begin
				itCmp_r[7:0] <= avs_writedata[7:0]; // [R10]
			end
			if (regHit(wordAddr, peirq_pkg::OFF_ITCTRL, wrTake, avs_byteenable[1])) begin
				itCmp_r[peirq_pkg::CMP_W-1:8] <= avs_writedata[peirq_pkg::CMP_W-1:8];
				itRun_r <= avs_writedata[peirq_pkg::RUN_BIT]; // [R9]
			end
		end
	end

	assign timerCfg.run = itRun_r;
	assign timerCfg.cmp = itCmp_r;

	// flag set and clear terms
	always_comb begin
		pinSet = pinEdge;
		pinClr = irqAck[peirq_pkg::PIN_N-1:0]; // [R12]
		pinMaskWr = '0;
		pinMaskVal = '0;
		for (int i = 0; i < peirq_pkg::PIN_LO_N; i++) begin
			if (regHit(wordAddr, peirq_pkg::OFF_FLAG_LO, wrTake, avs_byteenable[0])) begin
				pinSet[i] = pinSet[i] | avs_writedata[peirq_pkg::PIN_LO_LSB + i];
				pinClr[i] = pinClr[i] | ~avs_writedata[peirq_pkg::PIN_LO_LSB + i]; // [R6]
			end
			if (regHit(wordAddr, peirq_pkg::OFF_MASK_LO, wrTake, avs_byteenable[0])) begin
				pinMaskWr[i] = 1'b1;
				pinMaskVal[i] = avs_writedata[peirq_pkg::PIN_LO_LSB + i]; // [R8]
			end
		end
		for (int i = peirq_pkg::PIN_LO_N; i < peirq_pkg::PIN_N; i++) begin
			if (regHit(wordAddr, peirq_pkg::OFF_FLAG_EXT, wrTake, avs_byteenable[0])) begin
				pinSet[i] = pinSet[i] | avs_writedata[i - peirq_pkg::PIN_LO_N];
				pinClr[i] = pinClr[i] | ~avs_writedata[i - peirq_pkg::PIN_LO_N];
			end
			if (regHit(wordAddr, peirq_pkg::OFF_MASK_EXT, wrTake, avs_byteenable[0])) begin
				pinMaskWr[i] = 1'b1;
				pinMaskVal[i] = avs_writedata[i - peirq_pkg::PIN_LO_N];
			end
		end
	end

	always_comb begin
		timerSet = intervalEvent;
		timerClr = irqAck[peirq_pkg::IRQ_TIMER]; // [R12]
		if (regHit(wordAddr, peirq_pkg::OFF_FLAG_HI, wrTake, avs_byteenable[0])) begin
			timerSet = timerSet | avs_writedata[peirq_pkg::TIMER_BIT];
			timerClr = timerClr | ~avs_writedata[peirq_pkg::TIMER_BIT]; // [R6]
		end
	end

	// request flags, set wins over clear
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pinFlag_r <= '0;
			timerFlag_r <= 1'b0;
		end else if (clkEn) begin
			for (int i = 0; i < peirq_pkg::PIN_N; i++) begin
				pinFlag_r[i] <= peirq_pkg::flagNext(pinFlag_r[i], pinSet[i], pinClr[i]); // [R5] [R12]
			end
			timerFlag_r <= peirq_pkg::flagNext(timerFlag_r, timerSet, timerClr); // [R5] [R12]
		end
	end

	// mask registers
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pinMask_r <= peirq_pkg::RST_MASK;
			timerMask_r <= peirq_pkg::RST_TMASK;
		end else begin
			for (int i = 0; i < peirq_pkg::PIN_N; i++) begin
				if (pinMaskWr[i]) begin
					pinMask_r[i] <= pinMaskVal[i]; // [R8]
				end
			end
			if (regHit(wordAddr, peirq_pkg::OFF_MASK_HI, wrTake, avs_byteenable[0])) begin
				timerMask_r <= avs_writedata[peirq_pkg::TIMER_BIT]; // [R8]
			end
		end
	end

	// service requests to the cpu
	assign irqReq[peirq_pkg::PIN_N-1:0] = pinFlag_r & ~pinMask_r; // [R7]
	assign irqReq[peirq_pkg::IRQ_TIMER] = timerFlag_r & ~timerMask_r; // [R7]
	assign intervalTimerIrq = intervalEvent;

	peirq_edge_detect uEdge (
		.clock(clock),
		.rst_n(rst_n),
		.clkEn(clkEn),
		.pinIn(pinIn),
		.riseSel(riseSel_r),
		.fallSel(fallSel_r),
		.pinEdge(pinEdge)
	);

	peirq_interval_timer uTimer (
		.clock(clock),
		.rst_n(rst_n),
		.clkEn(clkEn),
		.subClockIn(subClockIn),
		.lowOscClockIn(lowOscClockIn),
		.clkCfg(clkCfg),
		.cfg(timerCfg),
		.intervalEvent(intervalEvent),
		.count(intervalCount)
	);
endmodule : peirq_top
`default_nettype wire

//--- sim/peirq_props.sv
// checker for bus handshake, interval timer and acknowledge behaviour
// assumes count clocks slower than clock/4 and a nonzero compare value
`timescale 1ns/1ps
`default_nettype none
module peirq_props (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clkEn,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic [peirq_pkg::IRQ_N-1:0] irqAck,
	input wire logic [peirq_pkg::IRQ_N-1:0] irqReq,
	input wire logic intervalTimerIrq,
	input wire logic [peirq_pkg::CMP_W-1:0] intervalCount
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	wait_idle_a: assert property (!avs_read && !avs_write |-> !avs_waitrequest)
		else $error("waitrequest without request");
	wait_one_a: assert property (clkEn && (avs_read || avs_write) && avs_waitrequest
		|=> !avs_waitrequest || !clkEn) else $error("answer not one cycle later");
	rd_upper_a: assert property (avs_readdata[31:16] == 16'h0000)
		else $error("upper read data not zero");
	pulse_wrap_a: assert property (intervalTimerIrq |-> intervalCount == 12'h000)
		else $error("pulse without wrap");
	pulse_gap_a: assert property (intervalTimerIrq |=> !intervalTimerIrq [*7])
		else $error("pulses too close");
	count_step_a: assert property ($changed(intervalCount) |-> intervalCount == 12'h000
		|| intervalCount == $past(intervalCount) + 12'h001) else $error("count skipped");
	count_dwell_a: assert property ($changed(intervalCount) && intervalCount != 12'h000
		|=> (intervalCount == 12'h000 || $stable(intervalCount)) [*3])
		else $error("count ticks too fast");
	ack_clear_a: assert property (irqAck[8] && !intervalTimerIrq && !avs_write
		|=> !irqReq[8]) else $error("ack did not clear");
	cover property (intervalTimerIrq);
	cover property (irqAck[8]);
	cover property (avs_read && !avs_waitrequest);
endmodule : peirq_props
bind peirq_top peirq_props u_props (.clock(clock), .rst_n(rst_n), .clkEn(clkEn),
	.avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .irqAck(irqAck), .irqReq(irqReq),
	.intervalTimerIrq(intervalTimerIrq), .intervalCount(intervalCount));
`default_nettype wire

//--- sim/peirq_far_side.sv
// pins, free-running count clocks and acknowledging cpu
// assumes bench sets pin levels and acknowledge wishes
`timescale 1ns/1ps
`default_nettype none
module peirq_far_side #(
	parameter int SUB_HALF = 5,
	parameter int LOW_HALF = 7
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [7:0] pinLevel,
	input wire logic [8:0] ackReq,
	input wire logic [8:0] irqReq,
	output logic [7:0] pinIn,
	output logic subClockIn,
	output logic lowOscClockIn,
	output logic [8:0] irqAck
);
	int subCnt_r;
	int lowCnt_r;
	assign pinIn = pinLevel;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			subCnt_r <= 0;
			lowCnt_r <= 0;
			subClockIn <= 1'b0;
			lowOscClockIn <= 1'b0;
			irqAck <= 9'h000;
		end else begin
			subCnt_r <= (subCnt_r == SUB_HALF - 1) ? 0 : subCnt_r + 1;
			lowCnt_r <= (lowCnt_r == LOW_HALF - 1) ? 0 : lowCnt_r + 1;
			if (subCnt_r == SUB_HALF - 1) subClockIn <= ~subClockIn;
			if (lowCnt_r == LOW_HALF - 1) lowOscClockIn <= ~lowOscClockIn;
			irqAck <= ackReq & irqReq & ~irqAck;
		end
	end
endmodule : peirq_far_side
`default_nettype wire

//--- sim/peirq_top_tb.sv
// self-checking bench: registers, pin edges, masks, interval timer
// assumes the far-side model makes pins, count clocks and acks
`timescale 1ns/1ps
`default_nettype none
module peirq_top_tb;
	localparam int SUB_HALF = 5;
	localparam int LOW_HALF = 7;
	localparam int CMP = 3;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic clkEn = 1'b1;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [3:0] avs_byteenable = 4'h0;
	logic [31:0] avs_readdata, rd;
	logic avs_waitrequest, subClockIn, lowOscClockIn, intervalTimerIrq;
	logic [7:0] pinLevel = 8'h00;
	logic [7:0] pinIn;
	logic [8:0] ackReq = 9'h000;
	logic [8:0] irqAck, irqReq;
	logic [11:0] intervalCount, c;
	int badCount = 0;
	int nChecks = 0;
	always #12.5 clock = ~clock;
	peirq_top uut (.clock, .rst_n, .clkEn, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .pinIn,
		.subClockIn, .lowOscClockIn, .irqAck, .irqReq, .intervalTimerIrq, .intervalCount);
	peirq_far_side #(.SUB_HALF(SUB_HALF), .LOW_HALF(LOW_HALF)) far (.clock, .rst_n,
		.pinLevel, .ackReq, .irqReq, .pinIn, .subClockIn, .lowOscClockIn, .irqAck);
	task final_report;
		$display("checks=%0d errors=%0d", nChecks, badCount);
		if (badCount == 0 && nChecks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : final_report
	task chk(input logic [31:0] got, input logic [31:0] exp);
		nChecks++;
		if (got !== exp) begin
			badCount++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= 4'h3;
		avs_read <= !wr;
		avs_write <= wr;
		do @(posedge clock); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus
	task wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr
	task rdc(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0000_0000);
		chk(rd, exp);
	endtask : rdc
	task pin(input logic v);
		@(posedge clock);
		pinLevel[1] <= v;
		repeat (8) @(posedge clock);
		@(negedge clock);
	endtask : pin
	task ack(input int n);
		@(posedge clock);
		ackReq[n] <= 1'b1;
		repeat (3) @(posedge clock);
		ackReq[n] <= 1'b0;
		@(negedge clock);
	endtask : ack
	task wait_pulse;
		do @(negedge clock); while (intervalTimerIrq !== 1'b1);
	endtask : wait_pulse
	task measure(input int half);
		int n;
		wait_pulse();
		n = 0;
		do begin
			@(negedge clock);
			n++;
		end while (intervalTimerIrq !== 1'b1);
		chk(32'(n), 32'((CMP + 1) * 2 * half));
	endtask : measure
	task t_regs;
		rdc(peirq_pkg::OFF_ITCTRL, 32'h0000_0FFF);
		rdc(peirq_pkg::OFF_MASK_HI, 32'h0000_0004);
		rdc(peirq_pkg::OFF_FLAG_LO, 32'h0000_0000);
		rdc(peirq_pkg::OFF_MASK_EXT, 32'h0000_0003);
		rdc(8'h3C, 32'h0000_0000);
		wr(peirq_pkg::OFF_FLAG_EXT, 32'h0000_0001);
		rdc(peirq_pkg::OFF_FLAG_EXT, 32'h0000_0001);
		wr(peirq_pkg::OFF_FLAG_EXT, 32'h0000_0000);
		rdc(peirq_pkg::OFF_FLAG_EXT, 32'h0000_0000);
		wr(peirq_pkg::OFF_RISE, 32'h0000_00A5);
		rdc(peirq_pkg::OFF_RISE, 32'h0000_00A5);
		wr(peirq_pkg::OFF_ITCTRL, 32'h0000_7005);
		rdc(peirq_pkg::OFF_ITCTRL, 32'h0000_0005);
	endtask : t_regs
	task t_edges;
		logic [1:0] m;
		wr(peirq_pkg::OFF_MASK_LO, 32'h0000_00F7);
		for (int i = 0; i < 4; i++) begin
			m = 2'(i);
			wr(peirq_pkg::OFF_RISE, {30'h0, m[1], 1'b0});
			wr(peirq_pkg::OFF_FALL, {30'h0, m[0], 1'b0});
			wr(peirq_pkg::OFF_FLAG_LO, 32'h0000_0000);
			pin(1'b1);
			chk(32'(irqReq[1]), 32'(m[1]));
			wr(peirq_pkg::OFF_FLAG_LO, 32'h0000_0000);
			pin(1'b0);
			chk(32'(irqReq[1]), 32'(m[0]));
			rdc(peirq_pkg::OFF_FLAG_LO, {28'h0, m[0], 3'h0});
		end
	endtask : t_edges
	task t_mask;
		wr(peirq_pkg::OFF_RISE, 32'h0000_0002);
		wr(peirq_pkg::OFF_FALL, 32'h0000_0000);
		wr(peirq_pkg::OFF_MASK_LO, 32'h0000_00FF);
		wr(peirq_pkg::OFF_FLAG_LO, 32'h0000_0000);
		rdc(peirq_pkg::OFF_FLAG_LO, 32'h0000_0000);
		pin(1'b1);
		chk(32'(irqReq[1]), 32'h0000_0000);
		rdc(peirq_pkg::OFF_FLAG_LO, 32'h0000_0008);
		wr(peirq_pkg::OFF_MASK_LO, 32'h0000_00F7);
		@(negedge clock);
		chk(32'(irqReq[1]), 32'h0000_0001);
		ack(1);
		chk(32'(irqReq[1]), 32'h0000_0000);
		pin(1'b0);
	endtask : t_mask
	task t_timer;
		wr(peirq_pkg::OFF_CLKGATE, 32'h0000_0080);
		wr(peirq_pkg::OFF_SRCSEL, 32'h0000_0000);
		wr(peirq_pkg::OFF_MASK_HI, 32'h0000_0000);
		wr(peirq_pkg::OFF_ITCTRL, 32'h0000_8000 | CMP);
		measure(SUB_HALF);
		@(posedge clock);
		clkEn <= 1'b0;
		@(negedge clock);
		c = intervalCount;
		repeat (50) @(negedge clock);
		chk(32'(intervalCount), 32'(c));
		@(posedge clock);
		clkEn <= 1'b1;
		wait_pulse();
		rdc(peirq_pkg::OFF_FLAG_HI, 32'h0000_0004);
		wr(peirq_pkg::OFF_FLAG_HI, 32'h0000_0000);
		rdc(peirq_pkg::OFF_FLAG_HI, 32'h0000_0000);
		wait_pulse();
		ack(8);
		chk(32'(irqReq[8]), 32'h0000_0000);
		wr(peirq_pkg::OFF_CLKGATE, 32'h0000_0000);
		wr(peirq_pkg::OFF_SRCSEL, 32'h0000_0010);
		wr(peirq_pkg::OFF_CLKGATE, 32'h0000_0080);
		measure(LOW_HALF);
		do @(negedge clock); while (intervalCount !== 12'h002);
		wr(peirq_pkg::OFF_CLKGATE, 32'h0000_0000);
		repeat (6) @(negedge clock);
		c = intervalCount;
		repeat (100) @(negedge clock);
		chk(32'(intervalCount), 32'(c));
		wr(peirq_pkg::OFF_ITCTRL, 32'h0000_0000 | CMP);
		repeat (2) @(negedge clock);
		chk(32'(intervalCount), 32'h0000_0000);
	endtask : t_timer
	initial begin
		repeat (20) @(posedge clock);
		rst_n <= 1'b1;
		t_regs();
		t_edges();
		t_mask();
		t_timer();
		final_report();
	end
	initial begin
		repeat (20000) @(posedge clock);
		badCount++;
		final_report();
	end
endmodule : peirq_top_tb
`default_nettype wire
